// *** core/ecapr_regs.sv ***
/*
  APB register slice for one canceller pair: adaptation control
  registers and read-only receive/send input peak monitors.
  Assumes: core-side strobes and peaks are synchronous to mclk; APB
  master follows setup then access; one aligned 32-bit word per register.
*/
// The implementer's own choice: the APB slave port.
// Functional notes
// - Receive peak: 16-bit, high byte second register
// - Send peak: 16-bit, high byte second register
// - First canceller receive peak at 0C, 0D
// - First canceller send peak at 0E, 0F
// - Second canceller control register at 29, read/write
// - Second canceller send peak low at 2E
`timescale 1ns/1ps
module ecapr_regs #(
  parameter int unsigned ADDR_W = ecapr_pkg::ADDR_W
) (
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [ADDR_W-1:0]             paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire ecapr_pkg::ecapr_core_s  [1:0] core_in,
  output ecapr_pkg::ecapr_adapt_s      [1:0] adapt_out
);

  localparam int unsigned N = ecapr_pkg::NUM_EC;

  // Bus phase decode
  logic                 setup;       // First cycle of a transfer
  logic                 access;      // Completing cycle
  logic                 aligned;     // Word aligned byte address
  logic                 in_range;    // Address fits the index space
  ecapr_pkg::ecapr_idx_t reg_idx;    // Register index of paddr

  // Per-canceller selects and data
  logic [N-1:0]         sel_ctrl;
  logic [N-1:0]         sel_rin_lo;
  logic [N-1:0]         sel_rin_hi;
  logic [N-1:0]         sel_sin_lo;
  logic [N-1:0]         sel_sin_hi;
  logic [N-1:0]         hit_ec;      // Any register of this canceller
  logic [N-1:0]         wr_ctrl;     // Control write takes effect
  logic [N-1:0][7:0]    rd_part;     // Read byte of this canceller
  logic [N-1:0][7:0]    ctrl_ff;     // Adaptation control registers
  logic [N-1:0][7:0]    nxt_ctrl;
  ecapr_pkg::ecapr_peak_s [N-1:0] peak;

  // Combined read answer
  logic                 hit;         // Address maps to a register
  logic [7:0]           rd_byte;     // Selected register contents
  logic [31:0]          prdata_ff;   // Read data, loaded at setup
  logic                 slverr_ff;   // Error answer, loaded at setup
  logic [31:0]          nxt_prdata;
  logic                 nxt_slverr;

  // Phases: access always completes with no wait state
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign aligned = (paddr[1:0] == 2'h0);
  // Upper address bits beyond the index must be zero to map
  assign in_range = ((paddr >> ecapr_pkg::IDX_SHIFT) >> 6) == '0;
  assign reg_idx = ecapr_pkg::ecapr_idx_t'(paddr >> ecapr_pkg::IDX_SHIFT);

  // One slice per canceller; the tables hold both address sets
  for (genvar i = 0; i < N; i++)
  begin : g_ec
    // Address decode against this canceller's index table
    assign sel_ctrl[i]   = aligned & in_range &
                           (reg_idx == ecapr_pkg::IDX_CTRL[i]);
    assign sel_rin_lo[i] = aligned & in_range &
                           (reg_idx == ecapr_pkg::IDX_RIN_LO[i]);
    assign sel_rin_hi[i] = aligned & in_range &
                           (reg_idx == ecapr_pkg::IDX_RIN_HI[i]);
    assign sel_sin_lo[i] = aligned & in_range &
                           (reg_idx == ecapr_pkg::IDX_SIN_LO[i]);
    assign sel_sin_hi[i] = aligned & in_range &
                           (reg_idx == ecapr_pkg::IDX_SIN_HI[i]);
    assign hit_ec[i] = sel_ctrl[i] | sel_rin_lo[i] | sel_rin_hi[i] |
                       sel_sin_lo[i] | sel_sin_hi[i];

    // Only the control register accepts writes; peaks drop them
    assign wr_ctrl[i] = access & pwrite & sel_ctrl[i];
    // Bits 7 and 3 are not stored and read back as zero
    assign nxt_ctrl[i] = wr_ctrl[i] ?
                         (pwdata[7:0] & ecapr_pkg::CTRL_WMASK) :
                         ctrl_ff[i];

    // Read selection; selects within one canceller are exclusive
    assign rd_part[i] = sel_ctrl[i]   ? ctrl_ff[i] :
                        sel_rin_lo[i] ? peak[i].rin_lo :
                        sel_rin_hi[i] ? peak[i].rin_hi :
                        sel_sin_lo[i] ? peak[i].sin_lo :
                        sel_sin_hi[i] ? peak[i].sin_hi :
                        8'h00;

    // Control register storage, holds hold and rate fields
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
        ctrl_ff[i] <= ecapr_pkg::CTRL_RESET;
      else
        ctrl_ff[i] <= nxt_ctrl[i];
    end

    // Peak capture, divider and hold application
    ecapr_canceller ecapr_canceller_inst (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .ctrl      (ctrl_ff[i]),
      .core      (core_in[i]),
      .rd_rin_lo (setup & ~pwrite & sel_rin_lo[i]),
      .rd_sin_lo (setup & ~pwrite & sel_sin_lo[i]),
      .peak      (peak[i]),
      .adapt     (adapt_out[i])
    );

    a_ctrl_write: assert property (
      @(posedge mclk) disable iff (!rst_n)
      wr_ctrl[i] |=> ctrl_ff[i] ==
        ($past(pwdata[7:0]) & ecapr_pkg::CTRL_WMASK))
      else $error("control write not stored");

    a_ctrl_zero_bits: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ctrl_ff[i][7] == 1'b0 && ctrl_ff[i][3] == 1'b0)
      else $error("reserved control bits not zero");

    a_ro_ignore: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (access && pwrite && !sel_ctrl[i])
        |=> $stable(ctrl_ff[i]))
      else $error("peak write altered control register");
  end

  // Canceller address sets are disjoint, so an OR merges them
  assign hit     = |hit_ec;
  assign rd_byte = rd_part[0] | rd_part[1];

  // Read data sampled in setup so prdata comes from a flip-flop;
  // the trade is that reads reflect the peak of the setup cycle
  assign nxt_prdata = (setup & ~pwrite) ? {24'h000000, rd_byte} :
                      setup ? 32'h00000000 : prdata_ff;
  // Unmapped or misaligned addresses answer with an error
  assign nxt_slverr = setup ? ~hit : slverr_ff;

  // Bus answer registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_ff <= 32'h00000000;
      slverr_ff <= 1'b0;
    end
    else
    begin
      prdata_ff <= nxt_prdata;
      slverr_ff <= nxt_slverr;
    end
  end

  // Handshake outputs are combinational and only valid in access
  assign prdata  = prdata_ff;
  assign pready  = access;
  assign pslverr = access & slverr_ff;

  a_rin_a_map: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (setup && !pwrite && paddr == ADDR_W'(32'h0C << 2))
      |=> prdata == {24'h000000, $past(peak[0].rin_lo)})
    else $error("first receive peak low byte misplaced");

  a_rin_hi_map: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (setup && !pwrite && paddr == ADDR_W'(32'h0D << 2))
      |=> prdata[7:0] == $past(peak[0].rin_hi) && prdata[31:8] == '0)
    else $error("first receive peak high byte misplaced");

  a_sin_a_map: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (setup && !pwrite && paddr == ADDR_W'(32'h0F << 2))
      |=> prdata == {24'h000000, $past(peak[0].sin_hi)})
    else $error("first send peak high byte misplaced");

  a_sin_b_map: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (setup && !pwrite && paddr == ADDR_W'(32'h2E << 2))
      |=> prdata == {24'h000000, $past(peak[1].sin_lo)})
    else $error("second send peak low byte misplaced");

  a_b_ctrl_read: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (setup && !pwrite && paddr == ADDR_W'(32'h29 << 2))
      |=> prdata == {24'h000000, $past(ctrl_ff[1])})
    else $error("second control register readback wrong");

  a_err_unmapped: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (setup && !hit) ##1 access |-> pslverr)
    else $error("unmapped access without error");

  c_b_ctrl_write: cover property (
    @(posedge mclk) disable iff (!rst_n) wr_ctrl[1]);

  c_peak_pair_read: cover property (
    @(posedge mclk) disable iff (!rst_n)
    (setup && sel_rin_lo[0]) ##[1:4] (setup && sel_rin_hi[0]));

endmodule // ecapr_regs

// *** core/ecapr_pkg.sv ***
/*
  Shared constants and carrier types for the echo canceller adaptation
  control and peak monitor register slice.
  Assumes: APB with 32-bit data, one aligned word per register, so the
  byte address of a register is its index shifted left by two.
*/
package ecapr_pkg;

  // Cancellers in one pair
  localparam int unsigned NUM_EC     = 2;
  // Byte address width on the bus
  localparam int unsigned ADDR_W     = 8;
  // Index to byte address shift
  localparam int unsigned IDX_SHIFT  = 2;

  // Register index type (byte address is index * 4)
  typedef logic [5:0] ecapr_idx_t;

  // First canceller register indices
  localparam ecapr_idx_t IDX_A_CTRL    = 6'h09;
  localparam ecapr_idx_t IDX_A_RIN_LO  = 6'h0C;
  localparam ecapr_idx_t IDX_A_RIN_HI  = 6'h0D;
  localparam ecapr_idx_t IDX_A_SIN_LO  = 6'h0E;
  localparam ecapr_idx_t IDX_A_SIN_HI  = 6'h0F;
  // Second canceller register indices
  localparam ecapr_idx_t IDX_B_CTRL    = 6'h29;
  localparam ecapr_idx_t IDX_B_RIN_LO  = 6'h2C;
  localparam ecapr_idx_t IDX_B_RIN_HI  = 6'h2D;
  localparam ecapr_idx_t IDX_B_SIN_LO  = 6'h2E;
  localparam ecapr_idx_t IDX_B_SIN_HI  = 6'h2F;

  // Per-canceller index tables, element 0 is the first canceller
  localparam ecapr_idx_t [1:0] IDX_CTRL   = {IDX_B_CTRL,   IDX_A_CTRL};
  localparam ecapr_idx_t [1:0] IDX_RIN_LO = {IDX_B_RIN_LO, IDX_A_RIN_LO};
  localparam ecapr_idx_t [1:0] IDX_RIN_HI = {IDX_B_RIN_HI, IDX_A_RIN_HI};
  localparam ecapr_idx_t [1:0] IDX_SIN_LO = {IDX_B_SIN_LO, IDX_A_SIN_LO};
  localparam ecapr_idx_t [1:0] IDX_SIN_HI = {IDX_B_SIN_HI, IDX_A_SIN_HI};

  // Adaptation control register layout
  localparam logic [7:0]  CTRL_RESET = 8'h54;
  localparam logic [7:0]  CTRL_WMASK = 8'h77;
  localparam int unsigned FIELD_W    = 3;
  localparam int unsigned HOLD_LSB   = 4;
  localparam int unsigned RATE_LSB   = 0;
  localparam logic [2:0]  HOLD_RESET = CTRL_RESET[6:4];
  // Slow adaptation divider counter width (2^7 ticks at most)
  localparam int unsigned RATE_CNT_W = 7;

  // Core-side measurement and event inputs for one canceller
  typedef struct packed {
    logic        peak_valid;  // New peak pair on rin/sin
    logic [15:0] rin_peak;    // Receive-input peak, two's complement
    logic [15:0] sin_peak;    // Send-input peak, two's complement
    logic        adapt_tick;  // Normal adaptation step strobe
    logic        conv_event;  // Path change, reset or bypass pulse
  } ecapr_core_s;

  // Adaptation outputs for one canceller
  typedef struct packed {
    logic       slow_tick;    // Slow convergence step strobe
    logic [2:0] hold_level;   // Hold field applied at last event
    logic [2:0] rate;         // Current slow rate field
  } ecapr_adapt_s;

  // Readable peak bytes for one canceller
  typedef struct packed {
    logic [7:0] rin_lo;
    logic [7:0] rin_hi;
    logic [7:0] sin_lo;
    logic [7:0] sin_hi;
  } ecapr_peak_s;

endpackage

// *** core/ecapr_canceller.sv ***
/*
  One canceller of the pair: peak capture with paired-byte shadow,
  slow convergence step divider and convergence hold application.
  Assumes: core inputs are on mclk; low-byte read pulses come from the
  bus slave in the APB setup cycle.
*/
`timescale 1ns/1ps
module ecapr_canceller (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           ctrl,
  input  wire ecapr_pkg::ecapr_core_s core,
  input  wire logic                 rd_rin_lo,
  input  wire logic                 rd_sin_lo,
  output ecapr_pkg::ecapr_peak_s    peak,
  output ecapr_pkg::ecapr_adapt_s   adapt
);

  localparam int unsigned CW = ecapr_pkg::RATE_CNT_W;

  // Ticks allowed before a slow step, 2^rate - 1
  function automatic logic [CW-1:0] rate_limit(input logic [2:0] r);
    rate_limit = CW'((8'h01 << r) - 8'h01);
  endfunction

  logic [15:0]   rin_ff;      // Latest receive-input peak
  logic [15:0]   sin_ff;      // Latest send-input peak
  logic [7:0]    rin_hi_ff;   // High byte frozen at low-byte read
  logic [7:0]    sin_hi_ff;   // High byte frozen at low-byte read
  logic [CW-1:0] cnt_ff;      // Normal ticks seen since last step
  logic          slow_ff;     // Registered slow step strobe
  logic [2:0]    hold_ff;     // Hold level applied at last event
  logic [2:0]    rate;        // Rate field
  logic [2:0]    hold;        // Hold field
  logic [CW-1:0] limit;       // Divider wrap point
  logic          wrap;        // Slow step due this tick
  logic [CW-1:0] nxt_cnt;

  assign rate  = ctrl[ecapr_pkg::RATE_LSB +: ecapr_pkg::FIELD_W];
  assign hold  = ctrl[ecapr_pkg::HOLD_LSB +: ecapr_pkg::FIELD_W];
  assign limit = rate_limit(rate);
  // Rate zero never wraps, so adaptation stops
  assign wrap  = core.adapt_tick & (rate != 3'h0) & (cnt_ff >= limit);
  // Counter held at zero while stopped; >= guards a shrunk rate
  assign nxt_cnt = (rate == 3'h0) ? '0 :
                   !core.adapt_tick ? cnt_ff :
                   wrap ? '0 : CW'(cnt_ff + 1'b1);

  // Divider and step strobe
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff  <= '0;
      slow_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      slow_ff <= wrap;
    end
  end

  // Peak capture; both values come from one measurement strobe
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rin_ff <= 16'h0000;
      sin_ff <= 16'h0000;
    end
    else if (core.peak_valid)
    begin
      rin_ff <= core.rin_peak;
      sin_ff <= core.sin_peak;
    end
  end

  // Shadow high bytes, so low then high reads form one value
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rin_hi_ff <= 8'h00;
      sin_hi_ff <= 8'h00;
    end
    else
    begin
      if (rd_rin_lo)
        rin_hi_ff <= rin_ff[15:8];
      if (rd_sin_lo)
        sin_hi_ff <= sin_ff[15:8];
    end
  end

  // Hold level takes effect only at a convergence event
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      hold_ff <= ecapr_pkg::HOLD_RESET;
    else if (core.conv_event)
      hold_ff <= hold;
  end

  assign peak.rin_lo     = rin_ff[7:0];
  assign peak.rin_hi     = rin_hi_ff;
  assign peak.sin_lo     = sin_ff[7:0];
  assign peak.sin_hi     = sin_hi_ff;
  assign adapt.slow_tick = slow_ff;
  assign adapt.hold_level = hold_ff;
  assign adapt.rate      = rate;

  a_rate_zero_stop: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (rate == 3'h0) [*2] |-> !slow_ff)
    else $error("slow step while rate is zero");

  a_rate_step_due: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (core.adapt_tick && rate != 3'h0 && cnt_ff == limit) |=> slow_ff)
    else $error("slow step missing at divider wrap");

  a_rin_capture: assert property (
    @(posedge mclk) disable iff (!rst_n)
    core.peak_valid |=> {rin_ff[15:8], peak.rin_lo} == $past(core.rin_peak))
    else $error("receive peak not captured");

  a_sin_capture: assert property (
    @(posedge mclk) disable iff (!rst_n)
    core.peak_valid |=> {rin_ff[15:8], sin_ff} ==
      {$past(core.rin_peak[15:8]), $past(core.sin_peak)})
    else $error("send peak not captured with receive peak");

  a_pair_shadow: assert property (
    @(posedge mclk) disable iff (!rst_n)
    rd_rin_lo |=> peak.rin_hi == $past(rin_ff[15:8]))
    else $error("high byte shadow not from same value");

  a_hold_apply: assert property (
    @(posedge mclk) disable iff (!rst_n)
    core.conv_event ##1 !core.conv_event |-> adapt.hold_level == $past(hold, 1))
    else $error("hold level not applied at event");

  c_slow_step: cover property (
    @(posedge mclk) disable iff (!rst_n) rate == 3'h7 ##1 slow_ff);

endmodule // ecapr_canceller

// *** dv/ecapr_regs_tb.sv ***
/*
  Self-checking testbench for the adaptation control and peak monitor
  register slice: APB master tasks, core-side strobes, one task a test.
  Assumes: zero wait-state slave, 10 MHz mclk, byte address = index * 4.
*/
`timescale 1ns/1ps
module ecapr_regs_tb;
  logic                            mclk;       // 10 MHz clock
  logic                            rst_n;      // Async reset, active low
  logic                            psel;       // APB select
  logic                            penable;    // APB enable
  logic                            pwrite;     // APB direction
  logic [7:0]                      paddr;      // APB byte address
  logic [31:0]                     pwdata;     // APB write data
  logic [31:0]                     prdata;     // APB read data
  logic                            pready;     // APB ready
  logic                            pslverr;    // APB error
  ecapr_pkg::ecapr_core_s  [1:0]   core_in;    // Core strobes and peaks
  ecapr_pkg::ecapr_adapt_s [1:0]   adapt_out;  // Adaptation outputs
  int                              fail_count; // Mismatches seen
  int                              num_checks; // Comparisons made

  ecapr_regs ecapr_regs_inst (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .core_in   (core_in),
    .adapt_out (adapt_out)
  );

  // Free-running clock, 100 ns period
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Single comparison point, four-state safe
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    // Answer is taken at the same edge that saw pready
    rd  = prdata;
    err = pslverr;
    if (n >= 50)
      chk(32'h0, 32'h1, "pready never came");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read and compare data and error flag
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic eerr);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0, d, e);
    chk(d, exp, "read data");
    chk({31'h0, e}, {31'h0, eerr}, "read error flag");
  endtask

  // Write and compare error flag
  task automatic wr(input logic [7:0] a, input logic [31:0] wd,
                    input logic eerr);
    logic [31:0] d;
    logic        e;
    apb(1'b1, a, wd, d, e);
    chk({31'h0, e}, {31'h0, eerr}, "write error flag");
  endtask

  // One-cycle peak capture strobe on one canceller
  task automatic peak(input int i, input logic [15:0] r, input logic [15:0] s);
    @(posedge mclk);
    core_in[i].peak_valid <= 1'b1;
    core_in[i].rin_peak   <= r;
    core_in[i].sin_peak   <= s;
    @(posedge mclk);
    core_in[i].peak_valid <= 1'b0;
  endtask

  // Issue n back-to-back adaptation ticks and count slow steps
  task automatic ticks(input int i, input int n, output int cnt);
    cnt = 0;
    repeat (n)
    begin
      @(posedge mclk);
      core_in[i].adapt_tick <= 1'b1;
      if (adapt_out[i].slow_tick === 1'b1)
        cnt++;
    end
    @(posedge mclk);
    core_in[i].adapt_tick <= 1'b0;
    // Last step pulses a cycle after the final tick
    repeat (3)
    begin
      if (adapt_out[i].slow_tick === 1'b1)
        cnt++;
      @(posedge mclk);
    end
  endtask

  // Control reset values on both cancellers
  task automatic t_reset();
    rd(8'h24, 32'h54, 1'b0);
    rd(8'hA4, 32'h54, 1'b0);
    chk({29'h0, adapt_out[0].rate}, 32'h4, "reset rate");
    chk({29'h0, adapt_out[1].hold_level}, 32'h5, "reset hold");
    rd(8'h38, 32'h0, 1'b0);
    $display("test reset values done");
  endtask

  // Hold field applies only at a convergence event, per canceller
  task automatic t_hold();
    wr(8'hA4, 32'h62, 1'b0);
    rd(8'hA4, 32'h62, 1'b0);
    wr(8'h24, 32'h31, 1'b0);
    chk({29'h0, adapt_out[1].hold_level}, 32'h5, "hold early");
    @(posedge mclk);
    core_in[1].conv_event <= 1'b1;
    @(posedge mclk);
    core_in[1].conv_event <= 1'b0;
    @(posedge mclk);
    chk({29'h0, adapt_out[1].hold_level}, 32'h6, "hold applied");
    chk({29'h0, adapt_out[0].hold_level}, 32'h5, "hold other");
    $display("test hold field done");
  endtask

  // Slow step divider at rates 1, 3, 7 and stopped at 0
  task automatic t_rate();
    int c;
    wr(8'h24, 32'h30, 1'b0);
    ticks(0, 8, c);
    chk(c, 0, "rate 0 steps");
    wr(8'h24, 32'h31, 1'b0);
    ticks(0, 8, c);
    chk(c, 4, "rate 1 steps");
    wr(8'h24, 32'h33, 1'b0);
    ticks(0, 16, c);
    chk(c, 2, "rate 3 steps");
    wr(8'h24, 32'h37, 1'b0);
    ticks(0, 128, c);
    chk(c, 1, "rate 7 steps");
    chk({29'h0, adapt_out[0].rate}, 32'h7, "rate out");
    // Second canceller still at rate 2 from the hold test
    ticks(1, 8, c);
    chk(c, 2, "second rate 2 steps");
    chk({29'h0, adapt_out[1].rate}, 32'h2, "second rate out");
    $display("test slow rate done");
  endtask

  // Peak byte placement on both cancellers
  task automatic t_peaks();
    peak(0, 16'h8123, 16'h7F45);
    peak(1, 16'hC0DE, 16'h0A5B);
    rd(8'h30, 32'h23, 1'b0);
    rd(8'h34, 32'h81, 1'b0);
    rd(8'h38, 32'h45, 1'b0);
    rd(8'h3C, 32'h7F, 1'b0);
    rd(8'hB0, 32'hDE, 1'b0);
    rd(8'hB4, 32'hC0, 1'b0);
    rd(8'hB8, 32'h5B, 1'b0);
    rd(8'hBC, 32'h0A, 1'b0);
    $display("test peak placement done");
  endtask

  // Byte pair coherence across a new capture, and write immunity
  task automatic t_coherent();
    rd(8'h30, 32'h23, 1'b0);
    peak(0, 16'h1234, 16'hFEDC);
    rd(8'h34, 32'h81, 1'b0);
    wr(8'h30, 32'hFF, 1'b0);
    rd(8'h30, 32'h34, 1'b0);
    rd(8'h34, 32'h12, 1'b0);
    rd(8'h38, 32'hDC, 1'b0);
    rd(8'h3C, 32'hFE, 1'b0);
    $display("test peak coherence done");
  endtask

  // Unmapped and misaligned accesses are refused
  task automatic t_unmapped();
    rd(8'h40, 32'h0, 1'b1);
    rd(8'h25, 32'h0, 1'b1);
    wr(8'h26, 32'h00, 1'b1);
    wr(8'h40, 32'h00, 1'b1);
    rd(8'h24, 32'h37, 1'b0);
    $display("test unmapped done");
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #(5000 * 100);
    fail_count++;
    conclude();
  end

  // Main sequence
  initial
  begin
    fail_count = 0;
    num_checks = 0;
    rst_n      = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    core_in    = '0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_hold();
    t_rate();
    t_peaks();
    t_coherent();
    t_unmapped();
    conclude();
  end
endmodule // ecapr_regs_tb
